// [logic/reset_cause_pkg.sv]
// Constants, field layouts and enumerations for the reset cause sequencer.
// Assumes one 200 MHz clock and a synchronous active-low power-on reset.
// Function
// - Fourteen configuration bits live in one word; erased reads one, programmed zero.
// - Configuration space is reachable only while programming mode is on.
// - Configuration bits 7, 2 and 1 are unimplemented and read one.
// - Bit 6 low turns program memory read protection on.
// - Bit 5 high makes the pin an active-low reset with pull-up.
// - Bit 4 low enables the power-up delay, high disables it.
// - Bit 3 high enables the watchdog, low disables it.
// - Dip mode 10 detects while running, off in sleep, on after wake.
// - Six reset causes are told apart and reported.
// - Untied registers are unknown at power-on and kept through other resets.
// - Watchdog wake-up resumes without register init; watchdog reset initialises.
// - Each cause except a pin reset while running updates some of the time-out, power-down, power-on and dip flags.
// - Short pulses on the reset pin are filtered out.
// - A watchdog reset never drives the reset pin low.
// - Power-up delay is a fixed 64 ms, only after power-on or dip reset.
// - Internal reset stays asserted while the power-up delay counts.
// - Power-on holds reset until the supply-good indication is seen.
// - A dip resets only when supply-low persists past the minimum dip time.
// - Any reset waits for supply above threshold; power-on and dip resets then take the optional 64 ms.
// - A dip during the delay re-enters dip reset and restarts the delay.
// - The oscillator calibration word survives a bulk erase.
// - Delay starts after power-on ends; oscillator start-up follows the delay.
// - A reset pin held past all time-outs releases execution at once.
// - Power-on flag clears on power-on only; software writes it to one.
// - Dip flag clears on dip reset; software sets it; undefined when disabled.
package reset_cause_pkg;
    localparam logic [13:0] CONFIG_SPACE_LO = 14'h2000;
    localparam logic [13:0] CONFIG_WORD_ADDR = 14'h2007;
    localparam logic [13:0] CALIB_WORD_ADDR = 14'h2008;
    localparam logic [13:0] CONFIG_ERASED = 14'h3fff;
    localparam logic [13:0] CALIB_DEFAULT = 14'h3fff;
    localparam logic [13:0] CONFIG_UNIMPL_MASK = 14'h0086;
    localparam int CFG_DEBUG_BIT = 13;
    localparam int CFG_CLKOUT_BIT = 12;
    localparam int CFG_WRT_LSB = 10;
    localparam int CFG_DIP_LSB = 8;
    localparam int CFG_CP_BIT = 6;
    localparam int CFG_PINFN_BIT = 5;
    localparam int CFG_POWERUP_DELAY_TIMER_BIT = 4;
    localparam int CFG_WDT_BIT = 3;
    localparam int CFG_CLKSRC_BIT = 0;
    localparam logic [1:0] DIP_MODE_ALWAYS = 2'h3;
    localparam logic [1:0] DIP_MODE_AWAKE = 2'h2;
    localparam logic [6:0] STATUS_ADDR = 7'h03;
    localparam logic [8:0] POWER_CONTROL_FLAGS_ADDR = 9'h10f;
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam int POWER_CONTROL_FLAGS_POR_BIT = 1;
    localparam int POWER_CONTROL_FLAGS_DIP_BIT = 0;
    localparam logic DIP_FLAG_POWERON = 1'b1;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int POWERUP_DELAY_TIME_MS = 64;
    localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int PIN_FILTER_TIME_NS = 200;
    localparam int PIN_FILTER_CYCLES = (PIN_FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DIP_MIN_TIME_NS = 1000;
    localparam int DIP_MIN_CYCLES = (DIP_MIN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    typedef enum logic [3:0] {
        S_SUPPLY = 4'b0001,
        S_DELAY = 4'b0010,
        S_PIN = 4'b0100,
        S_RUN = 4'b1000
    } seq_state_e;
    typedef enum logic [5:0] {
        CAUSE_POWER_ON = 6'b000001,
        CAUSE_WDT_RUN = 6'b000010,
        CAUSE_WDT_SLEEP = 6'b000100,
        CAUSE_PIN_RUN = 6'b001000,
        CAUSE_PIN_SLEEP = 6'b010000,
        CAUSE_DIP = 6'b100000
    } reset_cause_e;
endpackage

// [logic/config_access_if.sv]
// Programming-port bundle between the sequencer and the configuration store.
// Assumes the single system clock; all signals are synchronous to it.
`timescale 1ns/10ps
interface config_access_if;
    logic prog_mode;
    logic [13:0] addr;
    logic write;
    logic [13:0] wdata;
    logic bulk_erase;
    logic [13:0] rdata;
    logic [13:0] config_word;
    logic [13:0] calib_word;
    modport store (input prog_mode, input addr, input write, input wdata, input bulk_erase,
        output rdata, output config_word, output calib_word);
    modport user (output prog_mode, output addr, output write, output wdata, output bulk_erase,
        input rdata, input config_word, input calib_word);
endinterface

// [logic/persistence_filter.sv]
// Raises held once raw has stayed high for HOLD_CYCLES clocks; drops with raw.
// Assumes raw is already synchronous to clock.
`timescale 1ns/10ps
module persistence_filter #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic raw,
    output logic held
);
    logic [15:0] count;
    wire count_done = (count >= 16'(HOLD_CYCLES - 1));

    always_ff @(posedge clock)
    begin
        if (!resetn || !raw)
        begin
            count <= 16'h0000;
            held <= 1'b0;
        end
        else
        begin
            if (!count_done)
                count <= count + 16'h0001;
            held <= count_done;
        end
    end

    logic [15:0] run_len;
    always_ff @(posedge clock)
    begin
        if (!resetn || !raw)
            run_len <= 16'h0000;
        else if (run_len != 16'hffff)
            run_len <= run_len + 16'h0001;
    end

    // A pulse shorter than the hold time never reaches the output
    property p_short_pulse_ignored;
        @(posedge clock) disable iff (!resetn)
        $rose(held) |-> (run_len >= 16'(HOLD_CYCLES));
    endproperty
    a_short_pulse_ignored: assert property (p_short_pulse_ignored)
        else $error("filter passed a pulse shorter than the hold time");
endmodule

// [logic/config_store.sv]
// Non-volatile configuration and calibration words behind the programming port.
// Assumes resetn models the first application of power to an erased part.
`timescale 1ns/10ps
module config_store (
    input wire logic clock,
    input wire logic resetn,
    config_access_if.store bus
);
    import reset_cause_pkg::*;
    logic [13:0] config_cells;
    logic [13:0] calib_cells;
    wire in_space = bus.prog_mode && (bus.addr >= CONFIG_SPACE_LO);
    wire hit_config = in_space && (bus.addr == CONFIG_WORD_ADDR);
    wire hit_calib = in_space && (bus.addr == CALIB_WORD_ADDR);
    wire [13:0] config_view = config_cells | CONFIG_UNIMPL_MASK;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            config_cells <= CONFIG_ERASED;
            calib_cells <= CALIB_DEFAULT;
        end
        else if (bus.prog_mode && bus.bulk_erase)
            config_cells <= CONFIG_ERASED;
        else if (hit_config && bus.write)
            config_cells <= config_cells & bus.wdata;
        else if (hit_calib && bus.write)
            calib_cells <= bus.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            bus.rdata <= 14'h3fff;
        else if (hit_config)
            bus.rdata <= config_view;
        else if (hit_calib)
            bus.rdata <= calib_cells;
        else
            bus.rdata <= 14'h3fff;
    end

    assign bus.config_word = config_view;
    assign bus.calib_word = calib_cells;

    property p_locked_outside_prog;
        @(posedge clock) disable iff (!resetn)
        !bus.prog_mode |=> $stable(config_cells) && $stable(calib_cells);
    endproperty
    a_locked_outside_prog: assert property (p_locked_outside_prog)
        else $error("configuration changed outside programming mode");

    property p_calib_survives_erase;
        @(posedge clock) disable iff (!resetn)
        bus.prog_mode && bus.bulk_erase |=> $stable(calib_cells) && (config_cells == CONFIG_ERASED);
    endproperty
    a_calib_survives_erase: assert property (p_calib_survives_erase)
        else $error("bulk erase touched calibration or left configuration programmed");

    property p_unimpl_read_one;
        @(posedge clock) disable iff (!resetn)
        hit_config |=> (bus.rdata[7] && bus.rdata[2] && bus.rdata[1]);
    endproperty
    a_unimpl_read_one: assert property (p_unimpl_read_one)
        else $error("unimplemented configuration bit read as zero");
endmodule

// [logic/reset_cause_sequencer.sv]
// On-chip reset controller: power-on, supply dip, reset pin and watchdog causes,
// power-up delay and the reset-cause flags. Assumes all inputs are synchronous
// to clock and that resetn is the power-on pulse, released once power appears.
`timescale 1ns/10ps
module reset_cause_sequencer #(
    parameter int POWERUP_DELAY = reset_cause_pkg::POWERUP_DELAY_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic supply_good,
    input wire logic supply_low,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic sleeping,
    input wire logic [8:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic prog_mode,
    input wire logic [13:0] prog_addr,
    input wire logic prog_write,
    input wire logic [13:0] prog_wdata,
    input wire logic prog_bulk_erase,
    output logic [13:0] prog_rdata,
    output logic chip_reset,
    output logic wake_resume,
    output logic oscillator_startup_start,
    output reset_cause_pkg::reset_cause_e last_cause,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic poweron_flag_n,
    output logic supply_dip_flag_n,
    output logic supply_dip_detect_enable,
    output logic watchdog_enable_bit,
    output logic code_read_protect,
    output logic reset_pin_function_select,
    output logic reset_pin_pullup_enable,
    output logic debugger_enable,
    output logic clock_out_pin_select,
    output logic [1:0] flash_write_protect_range,
    output logic clock_source_select,
    output logic [13:0] calibration_word
);
    import reset_cause_pkg::*;

    config_access_if cfg_bus ();
    assign cfg_bus.prog_mode = prog_mode;
    assign cfg_bus.addr = prog_addr;
    assign cfg_bus.write = prog_write;
    assign cfg_bus.wdata = prog_wdata;
    assign cfg_bus.bulk_erase = prog_bulk_erase;

    config_store store (
        .clock(clock),
        .resetn(resetn),
        .bus(cfg_bus)
    );

    wire [13:0] cfg = cfg_bus.config_word;
    wire [1:0] dip_mode = cfg[CFG_DIP_LSB +: 2];
    wire delay_enabled = !cfg[CFG_POWERUP_DELAY_TIMER_BIT];
    wire pin_is_reset = cfg[CFG_PINFN_BIT];
    wire wdt_enabled = cfg[CFG_WDT_BIT];

    // Mode 10 drops detection in sleep to save current; 01 and 00 leave it off
    wire dip_enabled = (dip_mode == DIP_MODE_ALWAYS) || ((dip_mode == DIP_MODE_AWAKE) && !sleeping);

    // The pin is only ever read; a watchdog reset stays internal
    wire pin_raw_low = pin_is_reset && !external_reset_pin_n;
    logic pin_held_low;
    persistence_filter #(
        .HOLD_CYCLES(PIN_FILTER_CYCLES)
    ) pin_filter (
        .clock(clock),
        .resetn(resetn),
        .raw(pin_raw_low),
        .held(pin_held_low)
    );

    logic dip_held;
    persistence_filter #(
        .HOLD_CYCLES(DIP_MIN_CYCLES)
    ) dip_filter (
        .clock(clock),
        .resetn(resetn),
        .raw(supply_low && dip_enabled),
        .held(dip_held)
    );

    seq_state_e state;
    seq_state_e next_state;
    logic delay_pending;
    logic [23:0] delay_count;
    logic sleep_at_reset;

    wire dip_event = dip_held;
    wire supply_ready = supply_good && !(dip_enabled && supply_low);
    wire delay_done = (delay_count >= 24'(POWERUP_DELAY - 1));
    wire wdt_fire = wdt_enabled && watchdog_timeout;
    wire run_wdt_reset = (state == S_RUN) && !dip_event && wdt_fire && !sleeping;
    wire run_wdt_wake = (state == S_RUN) && !dip_event && wdt_fire && sleeping;
    wire run_pin_reset = (state == S_RUN) && !dip_event && !wdt_fire && pin_held_low;
    wire take_dip = dip_event && (state != S_SUPPLY);
    wire leave_delay = (state == S_DELAY) && !dip_event && delay_done;

    always_comb
    begin
        next_state = state;
        case (state)
            S_SUPPLY:
            begin
                if (supply_ready)
                begin
                    if (delay_pending && delay_enabled)
                        next_state = S_DELAY;
                    else if (pin_held_low)
                        next_state = S_PIN;
                    else
                        next_state = S_RUN;
                end
            end
            S_DELAY:
            begin
                if (dip_event)
                    next_state = S_SUPPLY;
                else if (delay_done)
                    next_state = pin_held_low ? S_PIN : S_RUN;
            end
            S_PIN:
            begin
                if (dip_event)
                    next_state = S_SUPPLY;
                else if (!pin_held_low && supply_ready)
                    next_state = S_RUN;
            end
            S_RUN:
            begin
                if (dip_event || run_wdt_reset)
                    next_state = S_SUPPLY;
                else if (run_pin_reset)
                    next_state = S_PIN;
            end
            default: next_state = S_SUPPLY;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            state <= S_SUPPLY;
        else
            state <= next_state;
    end

    // The delay restarts from zero whenever it is entered again
    always_ff @(posedge clock)
    begin
        if (!resetn || state != S_DELAY)
            delay_count <= 24'h000000;
        else if (!delay_done)
            delay_count <= delay_count + 24'h000001;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            delay_pending <= 1'b1;
        else if (take_dip)
            delay_pending <= 1'b1;
        else if (run_wdt_reset || state == S_DELAY)
            delay_pending <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            chip_reset <= 1'b1;
            wake_resume <= 1'b0;
            oscillator_startup_start <= 1'b0;
            sleep_at_reset <= 1'b0;
        end
        else
        begin
            chip_reset <= (next_state != S_RUN);
            wake_resume <= run_wdt_wake;
            oscillator_startup_start <= leave_delay;
            sleep_at_reset <= sleeping;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            last_cause <= CAUSE_POWER_ON;
        else if (take_dip)
            last_cause <= CAUSE_DIP;
        else if (run_wdt_reset)
            last_cause <= CAUSE_WDT_RUN;
        else if (run_wdt_wake)
            last_cause <= CAUSE_WDT_SLEEP;
        else if (run_pin_reset)
            last_cause <= sleeping ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
    end

    // Flag writes from software lose to a hardware update in the same cycle
    wire status_sel = reg_write && (reg_addr[6:0] == STATUS_ADDR);
    wire power_control_flags_sel = reg_write && (reg_addr == POWER_CONTROL_FLAGS_ADDR);

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
        else if (take_dip)
        begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
        else if (run_wdt_reset)
            timeout_flag_n <= 1'b0;
        else if (run_wdt_wake)
        begin
            timeout_flag_n <= 1'b0;
            powerdown_flag_n <= 1'b0;
        end
        else if (run_pin_reset && sleeping)
        begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b0;
        end
        else if (status_sel && !run_pin_reset)
        begin
            timeout_flag_n <= reg_wdata[STATUS_TO_BIT];
            powerdown_flag_n <= reg_wdata[STATUS_PD_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            poweron_flag_n <= 1'b0;
            supply_dip_flag_n <= DIP_FLAG_POWERON;
        end
        else if (take_dip)
            supply_dip_flag_n <= 1'b0;
        else if (power_control_flags_sel)
        begin
            poweron_flag_n <= reg_wdata[POWER_CONTROL_FLAGS_POR_BIT];
            supply_dip_flag_n <= reg_wdata[POWER_CONTROL_FLAGS_DIP_BIT];
        end
    end

    wire [7:0] status_view = {3'h0, timeout_flag_n, powerdown_flag_n, 3'h0};
    wire [7:0] power_control_flags_view = {6'h00, poweron_flag_n, supply_dip_flag_n};
    wire [7:0] read_mux = (reg_addr[6:0] == STATUS_ADDR) ? status_view
        : (reg_addr == POWER_CONTROL_FLAGS_ADDR) ? power_control_flags_view : 8'h00;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
            prog_rdata <= 14'h3fff;
            calibration_word <= CALIB_DEFAULT;
        end
        else
        begin
            reg_rdata <= read_mux;
            prog_rdata <= cfg_bus.rdata;
            calibration_word <= cfg_bus.calib_word;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            supply_dip_detect_enable <= 1'b0;
            watchdog_enable_bit <= 1'b0;
            code_read_protect <= 1'b0;
            reset_pin_function_select <= 1'b1;
            reset_pin_pullup_enable <= 1'b1;
            debugger_enable <= 1'b0;
            clock_out_pin_select <= 1'b1;
            flash_write_protect_range <= 2'h3;
            clock_source_select <= 1'b1;
        end
        else
        begin
            supply_dip_detect_enable <= dip_enabled;
            watchdog_enable_bit <= wdt_enabled;
            code_read_protect <= !cfg[CFG_CP_BIT];
            reset_pin_function_select <= pin_is_reset;
            reset_pin_pullup_enable <= pin_is_reset;
            debugger_enable <= !cfg[CFG_DEBUG_BIT];
            clock_out_pin_select <= cfg[CFG_CLKOUT_BIT];
            flash_write_protect_range <= cfg[CFG_WRT_LSB +: 2];
            clock_source_select <= cfg[CFG_CLKSRC_BIT];
        end
    end

    property p_reset_during_delay;
        @(posedge clock) disable iff (!resetn)
        (state == S_DELAY) |-> chip_reset;
    endproperty
    a_reset_during_delay: assert property (p_reset_during_delay)
        else $error("internal reset released while the power-up delay counts");

    property p_wait_supply_good;
        @(posedge clock) disable iff (!resetn)
        (state == S_SUPPLY) && !supply_good |=> chip_reset && (state == S_SUPPLY);
    endproperty
    a_wait_supply_good: assert property (p_wait_supply_good)
        else $error("left power-on wait without supply good");

    sequence s_dip_in_run;
        (state == S_RUN) && dip_event;
    endsequence
    sequence s_dip_flags;
        !supply_dip_flag_n && timeout_flag_n && powerdown_flag_n && chip_reset
            && (last_cause == CAUSE_DIP);
    endsequence
    property p_dip_flags;
        @(posedge clock) disable iff (!resetn)
        s_dip_in_run |=> s_dip_flags;
    endproperty
    a_dip_flags: assert property (p_dip_flags)
        else $error("dip reset did not set its flags");

    property p_wake_no_reset;
        @(posedge clock) disable iff (!resetn)
        run_wdt_wake |=> wake_resume && !chip_reset && !timeout_flag_n && !powerdown_flag_n;
    endproperty
    a_wake_no_reset: assert property (p_wake_no_reset)
        else $error("watchdog wake-up asserted reset or missed its flags");

    sequence s_pin_release;
        (state == S_PIN) && !pin_held_low && supply_ready && !dip_event;
    endsequence
    property p_pin_release_immediate;
        @(posedge clock) disable iff (!resetn)
        s_pin_release |=> (state == S_RUN) && !chip_reset;
    endproperty
    a_pin_release_immediate: assert property (p_pin_release_immediate)
        else $error("pin release did not start execution at once");

    property p_dip_restarts_delay;
        @(posedge clock) disable iff (!resetn)
        (state == S_DELAY) && dip_event |=> (state == S_SUPPLY) ##1 (delay_count == 24'h000000);
    endproperty
    a_dip_restarts_delay: assert property (p_dip_restarts_delay)
        else $error("dip during the delay did not restart it");

    property p_no_delay_after_wdt;
        @(posedge clock) disable iff (!resetn)
        run_wdt_reset |=> !delay_pending;
    endproperty
    a_no_delay_after_wdt: assert property (p_no_delay_after_wdt)
        else $error("watchdog reset armed the power-up delay");

    property p_pin_sleep_flags;
        @(posedge clock) disable iff (!resetn)
        run_pin_reset && sleeping |=> timeout_flag_n && !powerdown_flag_n
            && (last_cause == CAUSE_PIN_SLEEP);
    endproperty
    a_pin_sleep_flags: assert property (p_pin_sleep_flags)
        else $error("pin reset in sleep set wrong flags");
endmodule

// [bench/supply_pin_model.sv]
// Supply comparators and the reset pin as seen from outside the device.
// Assumes the bench sets its requests just after a rising clock edge.
`timescale 1ns/10ps
module supply_pin_model (
    input wire logic power_on,
    input wire logic dip_req,
    input wire logic pin_low_req,
    output logic supply_good,
    output logic supply_low,
    output logic external_reset_pin_n
);
    // Good only once power is up and no dip is in progress
    assign supply_good = power_on & ~dip_req;
    assign supply_low = dip_req;
    // Released, the model drives the pin high itself; no weak pull-up is modelled
    assign external_reset_pin_n = pin_low_req ? 1'b0 : 1'b1;
endmodule

// [bench/reset_cause_sequencer_test.sv]
// Self-checking bench for the reset cause sequencer.
// Assumes a shortened power-up delay; the partner model supplies pin and supply levels.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module reset_cause_sequencer_test;
    import reset_cause_pkg::*;
    localparam int DLY = 300;
    typedef struct {int sel; logic [13:0] exp;} note_s;
    logic clock = 0, resetn = 0, pwr = 0, dip = 0, pin_low = 0, wdt = 0, sleeping = 0;
    logic supply_good, supply_low, external_reset_pin_n, reg_write = 0, prog_mode = 0, prog_write = 0;
    logic prog_bulk_erase = 0, chip_reset, wake_resume, osc_go, timeout_flag_n, powerdown_flag_n;
    logic poweron_flag_n, supply_dip_flag_n, watchdog_enable_bit;
    logic [8:0] reg_addr = 0, dec;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [13:0] prog_addr = 0, prog_wdata = 0, prog_rdata, r, calib;
    reset_cause_e last_cause;
    int n_errors = 0, n_checks = 0;
    logic [31:0] seed = 32'h9b23;
    note_s q[$], s;
    event take;
    always #2.5 clock = ~clock;
    supply_pin_model u_far (.power_on(pwr), .dip_req(dip), .pin_low_req(pin_low), .supply_good, .supply_low,
        .external_reset_pin_n);
    reset_cause_sequencer #(.POWERUP_DELAY(DLY)) u_dut (.clock, .resetn, .supply_good, .supply_low,
        .external_reset_pin_n, .watchdog_timeout(wdt), .sleeping, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
        .prog_mode, .prog_addr, .prog_write, .prog_wdata, .prog_bulk_erase, .prog_rdata, .chip_reset, .wake_resume,
        .oscillator_startup_start(osc_go), .last_cause, .timeout_flag_n, .powerdown_flag_n, .poweron_flag_n,
        .supply_dip_flag_n, .supply_dip_detect_enable(dec[8]), .watchdog_enable_bit, .code_read_protect(dec[7]),
        .reset_pin_function_select(dec[6]), .reset_pin_pullup_enable(dec[5]), .debugger_enable(dec[4]),
        .clock_out_pin_select(dec[3]), .flash_write_protect_range(dec[2:1]), .clock_source_select(dec[0]),
        .calibration_word(calib));
    function automatic logic [13:0] obs(int sel);
        case (sel)
            0: obs = prog_rdata;
            1: obs = {6'h0, reg_rdata};
            2: obs = {8'h0, last_cause};
            3: obs = {10'h0, timeout_flag_n, powerdown_flag_n, poweron_flag_n, supply_dip_flag_n};
            5: obs = {12'h0, wake_resume, osc_go};
            6: obs = {5'h0, dec};
            7: obs = calib;
            default: obs = {12'h0, chip_reset, watchdog_enable_bit};
        endcase
    endfunction
    // Results are noted by the driver and judged by this watcher in order
    always @(take)
        while (q.size() > 0)
        begin
            s = q.pop_front();
            `CHK(obs(s.sel), s.exp)
        end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic note(int sel, logic [13:0] e);
        q.push_back('{sel, e});
        ->take;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_rel(int n);
        int i;
        for (i = 0; i < n && chip_reset !== 1'b0; i++)
            step(1);
        if (chip_reset !== 1'b0)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic prog(logic m, logic [13:0] a, logic [13:0] d, logic w);
        prog_mode = m;
        prog_addr = a;
        prog_wdata = d;
        prog_write = w;
        step(1);
        prog_write = 0;
        prog_mode = 1;
        step(2);
    endtask
    task automatic wreg(logic [8:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1;
        step(1);
        reg_write = 0;
        step(2);
    endtask
    task automatic pulse_wdt();
        wdt = 1;
        step(1);
        note(5, {12'h0, sleeping, 1'b0});
        wdt = 0;
        step(3);
    endtask
    initial
    begin
        step(3);
        resetn = 1;
        // The power-up delay is only enabled by a programmed bit, so program it before power appears
        prog(1, CONFIG_WORD_ADDR, 14'h3fef, 1);
        note(0, 14'h3fef);
        note(4, 2'b11);
        pwr = 1;
        step(DLY - 2);
        note(4, 2'b11);
        wait_rel(12);
        note(5, 2'b01);
        note(6, 9'h16f);
        note(3, 4'b1101);
        note(2, CAUSE_POWER_ON);
        prog(1, CONFIG_WORD_ADDR, 14'h3ff7, 1);
        note(0, 14'h3fe7);
        note(4, 2'b00);
        prog(1, CONFIG_WORD_ADDR, 14'h0, 1);
        note(0, 14'h0086);
        note(6, 9'h090);
        r = 14'(xs());
        prog(1, CALIB_WORD_ADDR, r, 1);
        prog_bulk_erase = 1;
        step(1);
        prog_bulk_erase = 0;
        prog(1, CONFIG_WORD_ADDR, 0, 0);
        note(0, 14'h3fff);
        prog(1, CALIB_WORD_ADDR, 0, 0);
        note(0, r);
        note(7, r);
        prog(0, CONFIG_WORD_ADDR, 14'h0, 1);
        note(0, 14'h3fff);
        prog_mode = 0;
        wreg(9'h055, 8'hff);
        note(1, 0);
        wreg(POWER_CONTROL_FLAGS_ADDR, 8'h03);
        note(1, 8'h03);
        pulse_wdt();
        wait_rel(12);
        note(2, CAUSE_WDT_RUN);
        note(3, 4'b0111);
        pin_low = 1;
        step(20);
        pin_low = 0;
        step(3);
        note(4, 2'b01);
        pin_low = 1;
        step(60);
        note(4, 2'b11);
        pin_low = 0;
        wait_rel(4);
        note(2, CAUSE_PIN_RUN);
        note(3, 4'b0111);
        sleeping = 1;
        pulse_wdt();
        note(4, 2'b01);
        note(3, 4'b0011);
        note(2, CAUSE_WDT_SLEEP);
        // Dip mode 10 with the delay on; the dip filter is longer than nothing but shorter than the delay
        prog(1, CONFIG_WORD_ADDR, 14'h3eef, 1);
        dip = 1;
        step(250);
        note(4, 2'b01);
        sleeping = 0;
        step(100);
        dip = 0;
        step(2);
        note(4, 2'b01);
        dip = 1;
        step(250);
        note(4, 2'b11);
        dip = 0;
        step(10);
        dip = 1;
        step(210);
        note(4, 2'b11);
        dip = 0;
        step(DLY - 2);
        note(4, 2'b11);
        wait_rel(12);
        note(5, 2'b01);
        note(3, 4'b1110);
        note(2, CAUSE_DIP);
        step(2);
        give_verdict();
    end
endmodule
